/* File: uart_interrupt_unit_test.sv */
/* Self-checking bench for the UART channel interrupt unit.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module uart_interrupt_unit_test;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        rx_char_in, rx_overrun, rx_err_any, rx_activity, bit_tick, rx_pop_reg, tsr_empty;
  logic        tx_push_reg, xoff_det, xon_det, special_det, rts_n, cts_n_pin, fifo_en_reg;
  logic        sleep_en_reg, irq_reg;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tx_data_reg, fifo_control_reg, enhanced_feature_reg;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, char_bits, modem_delta, modem_lines;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [6:0]  rx_fill, tx_fill;
  logic [2:0]  rx_head_err;
  int          tests_run = 0;
  int          n_mismatch = 0;
  uui_top uut (.*);
  uui_host_model host (.*);
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    host.rd(a, d, r);
    `CHK(n, {2'b00, e}, {r, d[7:0]})
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v, r);
    `CHK("wresp", 2'b00, r)
  endtask
  task automatic t_reset;
    rc(8'h00, 8'h00, "mask");
    rc(8'h04, 8'h01, "src idle");
    `CHK("irq", 1'b0, irq_reg)
    host.rd(8'h20, d, r);
    `CHK("bad rd", 2'b10, r)
    host.wr(8'h20, 8'h00, r);
    `CHK("bad wr", 2'b10, r)
    host.rd(8'h1c, d, r);
    `CHK("tx rd", 2'b10, r)
  endtask
  task automatic t_line;
    w(8'h10, 8'h01);
    {rx_fill, tsr_empty, rx_head_err, rx_err_any} <= {7'd1, 1'b1, 3'b101, 1'b1};
    {rx_char_in, rx_overrun} <= 2'b11;
    @(posedge aclk);
    {rx_char_in, rx_overrun} <= 2'b00;
    rc(8'h08, 8'hf7, "lsr");
    rc(8'h08, 8'hf5, "lsr ovr");
    {rx_fill, tx_fill, tsr_empty, rx_head_err, rx_err_any} <= {7'd8, 7'd3, 5'b0};
    rc(8'h04, 8'hc1, "polled src");
    rc(8'h08, 8'h01, "polled lsr");
    rx_fill <= 7'd0;
    rc(8'h08, 8'h00, "lsr empty");
  endtask
  task automatic t_prio;
    w(8'h14, 8'hd0);
    `CHK("efr", 8'hd0, enhanced_feature_reg)
    w(8'h00, 8'hff);
    {rx_err_any, rx_fill, modem_delta, special_det} <= {1'b1, 7'd8, 4'h1, 1'b1};
    @(posedge aclk);
    {modem_delta, special_det} <= 5'b0;
    rc(8'h04, 8'hc6, "line");
    `CHK("irq", 1'b1, irq_reg)
    `CHK("sleep", 1'b1, sleep_en_reg)
    rx_err_any <= 1'b0;
    rc(8'h04, 8'hc4, "rx rdy");
    rx_fill <= 7'd7;
    rc(8'h04, 8'hc2, "tx rdy");
    rc(8'h04, 8'hc0, "modem");
    rc(8'h0c, 8'h01, "msr");
    rc(8'h04, 8'hd0, "special");
    rc(8'h04, 8'hc1, "serviced");
    step(2);
    `CHK("irq", 1'b0, irq_reg)
    xoff_det <= 1'b1;
    @(posedge aclk);
    xoff_det <= 1'b0;
    rc(8'h04, 8'hd0, "xoff");
    rc(8'h04, 8'hd0, "xoff held");
    xon_det <= 1'b1;
    @(posedge aclk);
    xon_det <= 1'b0;
    rc(8'h04, 8'hc1, "xon");
    rts_n <= 1'b1;
    rc(8'h04, 8'he0, "rts");
    rc(8'h0c, 8'h00, "msr");
    cts_n_pin <= 1'b0;
    step(4);
    cts_n_pin <= 1'b1;
    step(4);
    rc(8'h04, 8'he0, "cts");
    rc(8'h0c, 8'h00, "msr");
    rc(8'h04, 8'hc1, "flow clr");
  endtask
  task automatic t_tx;
    w(8'h00, 8'h00);
    w(8'h00, 8'h02);
    step(3);
    `CHK("tx irq", 1'b1, irq_reg)
    w(8'h1c, 8'h5a);
    step(2);
    `CHK("tx data", 8'h5a, tx_data_reg)
    rc(8'h04, 8'hc1, "tx clr");
    w(8'h14, 8'h30);
    tx_fill <= 7'd0;
    rc(8'h04, 8'hc1, "hdx busy");
    tsr_empty <= 1'b1;
    rc(8'h04, 8'hc2, "hdx empty");
    rc(8'h04, 8'hc1, "tx isr clr");
  endtask
  // Limit is 4 chars of one bit plus 12 bits: expiry on the 16th tick
  task automatic t_tmo;
    w(8'h00, 8'h01);
    {rx_fill, rx_activity} <= {7'd1, 1'b1};
    @(posedge aclk);
    {rx_activity, bit_tick} <= 2'b01;
    step(13);
    rc(8'h04, 8'hc1, "early");
    `CHK("tmo irq", 1'b1, irq_reg)
    rc(8'h04, 8'hcc, "timeout");
    rc(8'h18, 8'h3c, "rx hold");
    rc(8'h04, 8'hc1, "tmo clr");
    bit_tick <= 1'b0;
    w(8'h10, 8'h00);
    rc(8'h04, 8'h04, "non-fifo rx");
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    {rx_fill, rx_char_in, rx_overrun, rx_head_err, rx_err_any, rx_activity, bit_tick} = '0;
    {tx_fill, tsr_empty, xoff_det, xon_det, special_det, rts_n, modem_delta, modem_lines} = '0;
    {aresetn, ce, cts_n_pin, rx_data, char_bits} = {3'b011, 8'h3c, 4'h1};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_line;
    t_prio;
    t_tx;
    t_tmo;
    finish_test;
  end
endmodule
bind uui_top uui_checker chk (.*);

/* File: uui_checker.sv */
/* Assertions on the ports of the interrupt unit top.
   Assumes ce held high and one request per channel at a time. */
`timescale 1ns/100ps
module uui_checker (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  // Block outputs
  input logic        rx_pop_reg,
  input logic        tx_push_reg,
  input logic        fifo_en_reg,
  input logic [7:0]  fifo_control_reg,
  input logic [7:0]  enhanced_feature_reg,
  input logic        sleep_en_reg,
  input logic        irq_reg
);
  logic [7:0] aw_q;
  logic [7:0] ar_q;
  logic [7:0] w_q;
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fifo_enable_a: assert property ($rose(s_axi_bvalid) && aw_q == 8'h10 |-> fifo_en_reg == w_q[0] && fifo_control_reg[0] == w_q[0])
    else $error("fifo enable stale");
  sleep_gate_a: assert property (!$past(enhanced_feature_reg[4]) |-> !sleep_en_reg)
    else $error("sleep without enhanced enable");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rx_pop_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18 |=> rx_pop_reg)
    else $error("no pop on holding read");
  tx_push_a: assert property ($rose(s_axi_bvalid) && aw_q == 8'h1c |-> tx_push_reg)
    else $error("no push on holding write");
  src_flag_a: assert property ($rose(s_axi_rvalid) && ar_q == 8'h04 |-> s_axi_rdata[0] == !irq_reg)
    else $error("source bit 0 and irq disagree");
  src_fifo_a: assert property ($rose(s_axi_rvalid) && ar_q == 8'h04 |-> s_axi_rdata[7:6] == {2{fifo_en_reg}})
    else $error("source bits 7:6 wrong");
  read_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b00 |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

/* File: uui_host_model.sv */
/* Host processor model: AXI4-Lite master, one word per transfer.
   Assumes a slave on aclk; waits stay open until it answers. */
`timescale 1ns/100ps
module uui_host_model (
  // Clock
  input  logic        aclk,
  // Write channels
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  // Read channels
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // Accept the response one edge late so the slave must hold it
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Reads of source, line, modem status and receive holding carry the clearing side effects
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: uui_map.vh */
/*
 Register offsets, field positions, reset values and interrupt codes of the
 UART channel interrupt unit. Assumes inclusion by bare name, no processes.
*/
`ifndef UUI_MAP_VH
`define UUI_MAP_VH

// Register byte offsets on the AXI4-Lite slave
`define UUI_OFF_MASK      8'h00
`define UUI_OFF_SOURCE    8'h04
`define UUI_OFF_LINE      8'h08
`define UUI_OFF_MODEM     8'h0c
`define UUI_OFF_FIFO_CTL  8'h10
`define UUI_OFF_ENH       8'h14
`define UUI_OFF_RX_HOLD   8'h18
`define UUI_OFF_TX_HOLD   8'h1c

// Reset values
`define UUI_RST_MASK      8'h00
`define UUI_RST_FIFO_CTL  8'h00
`define UUI_RST_ENH       8'h00

// Field positions
`define UUI_FCR_EN        0
`define UUI_EFR_ENH       4
`define UUI_EFR_HDX       5
`define UUI_EFR_ARTS      6
`define UUI_EFR_ACTS      7

// Interrupt source codes, bits 5..0
`define UUI_CODE_LINE     6'h06
`define UUI_CODE_TMO      6'h0c
`define UUI_CODE_RECEIVE_READY_IRQ    6'h04
`define UUI_CODE_TRANSMIT_READY_IRQ    6'h02
`define UUI_CODE_MODEM    6'h00
`define UUI_CODE_XOFF     6'h10
`define UUI_CODE_FLOW     6'h20
`define UUI_CODE_NONE     6'h01

// Time-out: four character times plus this many bit times
`define UUI_TMO_CHARS     4
`define UUI_TMO_BITS      12

// AXI responses
`define UUI_RESP_OKAY     2'b00
`define UUI_RESP_SLVERR   2'b10

`endif

/* File: uui_rx_timer.v */
/*
 Receive time-out timer: counts bit ticks while armed and flags expiry after
 four character times plus twelve bit times. Assumes bit_tick is one cycle
 wide on aclk and that char_bits holds the bits per character frame.
*/
`timescale 1ns/100ps
`include "uui_map.vh"
module uui_rx_timer #(
  parameter CW = 7
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // Control
  input  wire          bit_tick,
  input  wire [3:0]    char_bits,
  input  wire          armed,
  input  wire          restart,
  // Status
  output reg           expired_reg
);
  reg  [CW-1:0] count_reg;
  wire [31:0]   limit_full;
  wire [CW-1:0] limit;

  // Full-width sum, cut to the counter width on purpose
  assign limit_full = (char_bits * `UUI_TMO_CHARS) + `UUI_TMO_BITS;
  assign limit      = limit_full[CW-1:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg   <= {CW{1'b0}};
      expired_reg <= 1'b0;
    end else if (ce) begin
      if (restart || !armed) begin
        count_reg   <= {CW{1'b0}};
        expired_reg <= 1'b0;
      end else if (bit_tick && !expired_reg) begin
        count_reg <= count_reg + 1'b1;
        if (count_reg + 1'b1 >= limit)
          expired_reg <= 1'b1;
      end
    end
  end
endmodule

/* File: uui_top.v */
/*
 Interrupt mask, prioritisation and status of one UART channel, with an
 AXI4-Lite register slave. Assumes the FIFO datapath, baud logic and modem
 logic run on aclk; only the clear-to-send pin is asynchronous.
*/
`timescale 1ns/100ps
`include "uui_map.vh"
// What this block does
// - FIFO receive interrupt follows trigger level
// - Data-ready set on arrival, cleared when empty
// - Mask bits 0-3 clear gives polled mode
// - Line status bits 1,2-4,5,6,7 reported
// - Mask bit 0 enables receive-ready interrupt
// - Mask bit 1 enables transmit-ready, immediate
// - Mask bit 2 enables line status interrupt
// - Bit 7 any error, bits 4:2 head
// - Mask bit 3 enables modem status interrupt
// - Mask bits 4-7 need enhanced enable; sleep
// - Mask bit 5 enables Xoff/special interrupt
// - Mask bit 6 enables RTS rise interrupt
// - Mask bit 7 enables CTS rise interrupt
// - Source register shows highest pending, others queue
// - Codes for priorities one to four
// - Codes for priorities five to seven, none
// - Time-out after four chars plus twelve bits
// - Transmit source trigger/empty, half-duplex fully empty
// - Clearing of line, receive, time-out, transmit
// - Clearing of modem, flow, Xoff, special
// - Source bit 0 low while pending
// - Source bits 7:6 show FIFO enable
// - FIFO control bit 0 enables FIFOs
module uui_top #(
  parameter FW = 7,
  parameter DEPTH = 64
) (
  // Clock, reset, enable
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // AXI4-Lite write
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Receive datapath
  input  wire [FW-1:0] rx_fill,
  input  wire          rx_char_in,
  input  wire          rx_overrun,
  input  wire [2:0]    rx_head_err,
  input  wire          rx_err_any,
  input  wire [7:0]    rx_data,
  input  wire          rx_activity,
  input  wire          bit_tick,
  input  wire [3:0]    char_bits,
  output reg           rx_pop_reg,
  // Transmit datapath
  input  wire [FW-1:0] tx_fill,
  input  wire          tsr_empty,
  output reg           tx_push_reg,
  output reg  [7:0]    tx_data_reg,
  // Flow control and modem
  input  wire          xoff_det,
  input  wire          xon_det,
  input  wire          special_det,
  input  wire          rts_n,
  input  wire          cts_n_pin,
  input  wire [3:0]    modem_delta,
  input  wire [3:0]    modem_lines,
  // Controls and interrupt
  output reg           fifo_en_reg,
  output reg  [7:0]    fifo_control_reg,
  output reg  [7:0]    enhanced_feature_reg,
  output reg           sleep_en_reg,
  output reg           irq_reg
);
  localparam [FW-1:0] DEPTH_W = DEPTH[FW-1:0];

  function [FW-1:0] rx_trig;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: rx_trig = 7'd8;
        2'd1: rx_trig = 7'd16;
        2'd2: rx_trig = 7'd56;
        default: rx_trig = 7'd60;
      endcase
    end
  endfunction

  function [FW-1:0] tx_trig;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: tx_trig = 7'd8;
        2'd1: tx_trig = 7'd16;
        2'd2: tx_trig = 7'd32;
        default: tx_trig = 7'd56;
      endcase
    end
  endfunction

  function [5:0] prio_code;
    input [6:0] p;
    begin
      if (p[0])      prio_code = `UUI_CODE_LINE;
      else if (p[1]) prio_code = `UUI_CODE_TMO;
      else if (p[2]) prio_code = `UUI_CODE_RECEIVE_READY_IRQ;
      else if (p[3]) prio_code = `UUI_CODE_TRANSMIT_READY_IRQ;
      else if (p[4]) prio_code = `UUI_CODE_MODEM;
      else if (p[5]) prio_code = `UUI_CODE_XOFF;
      else if (p[6]) prio_code = `UUI_CODE_FLOW;
      else           prio_code = `UUI_CODE_NONE;
    end
  endfunction

  // Registers and flags
  reg  [7:0]  interrupt_mask_reg;
  reg  [3:0]  msr_delta_reg;
  reg         overrun_reg;
  reg         rx_ready_reg;
  reg         tx_flag_reg;
  reg         tx_cond_d_reg;
  reg         mask1_d_reg;
  reg         xoff_reg;
  reg         special_reg;
  reg         rts_irq_reg;
  reg         cts_irq_reg;
  reg         rts_d_reg;
  reg         cts_s1_reg;
  reg         cts_s2_reg;
  reg         cts_d_reg;
  // AXI holding state
  reg         aw_hold_reg;
  reg         w_hold_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  wire        tmo_expired;
  wire        enh = enhanced_feature_reg[`UUI_EFR_ENH];
  wire [7:0]  mask_eff = {interrupt_mask_reg[7:4] & {4{enh}}, interrupt_mask_reg[3:0]};
  wire [FW-1:0] tx_space = DEPTH_W - tx_fill;
  wire        thr_empty = (tx_fill == {FW{1'b0}});
  wire        tx_all_empty = thr_empty && tsr_empty;
  wire        rx_at_trig = rx_fill >= rx_trig(fifo_control_reg[7:6]);
  wire        rx_nonempty = (rx_fill != {FW{1'b0}});
  wire [7:0]  line_status;
  reg         tx_cond;
  wire [6:0]  pend;
  wire [5:0]  cur_code;
  wire        do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire        do_read = s_axi_arvalid && s_axi_arready;
  wire        rd_src = do_read && (s_axi_araddr == `UUI_OFF_SOURCE);
  wire        rd_modem = do_read && (s_axi_araddr == `UUI_OFF_MODEM);
  wire        rd_line = do_read && (s_axi_araddr == `UUI_OFF_LINE);
  wire        rd_rhr = do_read && (s_axi_araddr == `UUI_OFF_RX_HOLD);
  wire        wr_thr = do_write && (aw_addr_reg == `UUI_OFF_TX_HOLD) && w_strb_reg[0];

  assign line_status = {rx_err_any, tx_all_empty, thr_empty,
                        rx_head_err, overrun_reg, rx_ready_reg};

  // Transmit-ready condition
  always @* begin
    if (!fifo_en_reg)
      tx_cond = thr_empty;
    else if (enhanced_feature_reg[`UUI_EFR_HDX])
      tx_cond = tx_all_empty;
    else
      tx_cond = (tx_space > tx_trig(fifo_control_reg[5:4])) || thr_empty;
  end

  // Pending sources in priority order; all gated by the mask
  assign pend[0] = mask_eff[2] && (overrun_reg || (|rx_head_err) || rx_err_any);
  assign pend[1] = mask_eff[0] && fifo_en_reg && tmo_expired;
  assign pend[2] = mask_eff[0] && (fifo_en_reg ? rx_at_trig : rx_nonempty);
  assign pend[3] = mask_eff[1] && tx_flag_reg;
  assign pend[4] = mask_eff[3] && (|msr_delta_reg);
  assign pend[5] = mask_eff[5] && (xoff_reg || special_reg);
  assign pend[6] = (mask_eff[6] && rts_irq_reg) || (mask_eff[7] && cts_irq_reg);
  assign cur_code = prio_code(pend);

  uui_rx_timer u_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .bit_tick    (bit_tick),
    .char_bits   (char_bits),
    .armed       (fifo_en_reg && rx_nonempty),
    .restart     (rx_activity || rd_rhr),
    .expired_reg (tmo_expired)
  );

  // Clear-to-send pin synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      cts_s1_reg <= 1'b1;
      cts_s2_reg <= 1'b1;
    end else if (ce) begin
      cts_s1_reg <= cts_n_pin;
      cts_s2_reg <= cts_s1_reg;
    end
  end

  // Status flags; a set always wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      overrun_reg   <= 1'b0;
      rx_ready_reg  <= 1'b0;
      tx_flag_reg   <= 1'b0;
      tx_cond_d_reg <= 1'b1;
      mask1_d_reg   <= 1'b0;
      msr_delta_reg <= 4'h0;
      xoff_reg      <= 1'b0;
      special_reg   <= 1'b0;
      rts_irq_reg   <= 1'b0;
      cts_irq_reg   <= 1'b0;
      rts_d_reg     <= 1'b1;
      cts_d_reg     <= 1'b1;
    end else if (ce) begin
      tx_cond_d_reg <= tx_cond;
      mask1_d_reg   <= mask_eff[1];
      rts_d_reg     <= rts_n;
      cts_d_reg     <= cts_s2_reg;
      if (rx_overrun)
        overrun_reg <= 1'b1;
      else if (rd_line)
        overrun_reg <= 1'b0;
      if (rx_char_in)
        rx_ready_reg <= 1'b1;
      else if (!rx_nonempty)
        rx_ready_reg <= 1'b0;
      if ((tx_cond && !tx_cond_d_reg) || (tx_cond && mask_eff[1] && !mask1_d_reg))
        tx_flag_reg <= 1'b1;
      else if (wr_thr || (rd_src && cur_code == `UUI_CODE_TRANSMIT_READY_IRQ))
        tx_flag_reg <= 1'b0;
      msr_delta_reg <= modem_delta | (rd_modem ? 4'h0 : msr_delta_reg);
      if (xoff_det)
        xoff_reg <= 1'b1;
      else if (xon_det)
        xoff_reg <= 1'b0;
      if (special_det)
        special_reg <= 1'b1;
      else if (rd_src && cur_code == `UUI_CODE_XOFF)
        special_reg <= 1'b0;
      if (enhanced_feature_reg[`UUI_EFR_ARTS] && rts_n && !rts_d_reg)
        rts_irq_reg <= 1'b1;
      else if (rd_modem)
        rts_irq_reg <= 1'b0;
      if (enhanced_feature_reg[`UUI_EFR_ACTS] && cts_s2_reg && !cts_d_reg)
        cts_irq_reg <= 1'b1;
      else if (rd_modem)
        cts_irq_reg <= 1'b0;
    end
  end

  // Interrupt output and sleep enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg      <= 1'b0;
      sleep_en_reg <= 1'b0;
    end else if (ce) begin
      irq_reg      <= (|pend);
      sleep_en_reg <= mask_eff[4];
    end
  end

  // AXI write channels: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UUI_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `UUI_OFF_MASK, `UUI_OFF_FIFO_CTL, `UUI_OFF_ENH, `UUI_OFF_TX_HOLD:
            s_axi_bresp <= `UUI_RESP_OKAY;
          `UUI_OFF_SOURCE, `UUI_OFF_LINE, `UUI_OFF_MODEM, `UUI_OFF_RX_HOLD:
            s_axi_bresp <= `UUI_RESP_OKAY;
          default:
            s_axi_bresp <= `UUI_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_mask_reg   <= `UUI_RST_MASK;
      fifo_control_reg     <= `UUI_RST_FIFO_CTL;
      enhanced_feature_reg <= `UUI_RST_ENH;
      fifo_en_reg          <= 1'b0;
      tx_push_reg          <= 1'b0;
      tx_data_reg          <= 8'h00;
    end else if (ce) begin
      tx_push_reg <= wr_thr;
      if (wr_thr)
        tx_data_reg <= w_data_reg[7:0];
      if (do_write && w_strb_reg[0]) begin
        case (aw_addr_reg)
          `UUI_OFF_MASK:
            interrupt_mask_reg <= w_data_reg[7:0];
          `UUI_OFF_FIFO_CTL: begin
            fifo_en_reg <= w_data_reg[`UUI_FCR_EN];
            if (w_data_reg[`UUI_FCR_EN]) begin
              fifo_control_reg[7:6] <= w_data_reg[7:6];
              if (enh)
                fifo_control_reg[5:4] <= w_data_reg[5:4];
              fifo_control_reg[3] <= w_data_reg[3];
            end
            fifo_control_reg[0] <= w_data_reg[`UUI_FCR_EN];
          end
          `UUI_OFF_ENH:
            enhanced_feature_reg <= w_data_reg[7:0];
          default: ;
        endcase
      end
    end
  end

  // AXI read channel, one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UUI_RESP_OKAY;
      rx_pop_reg    <= 1'b0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      rx_pop_reg    <= rd_rhr;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `UUI_RESP_OKAY;
        case (s_axi_araddr)
          `UUI_OFF_MASK:     s_axi_rdata <= {24'h000000, interrupt_mask_reg};
          `UUI_OFF_SOURCE:   s_axi_rdata <= {24'h000000, {2{fifo_en_reg}}, cur_code};
          `UUI_OFF_LINE:     s_axi_rdata <= {24'h000000, line_status};
          `UUI_OFF_MODEM:    s_axi_rdata <= {24'h000000, modem_lines, msr_delta_reg};
          `UUI_OFF_FIFO_CTL: s_axi_rdata <= {24'h000000, fifo_control_reg};
          `UUI_OFF_ENH:      s_axi_rdata <= {24'h000000, enhanced_feature_reg};
          `UUI_OFF_RX_HOLD:  s_axi_rdata <= {24'h000000, rx_data};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UUI_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
